// ===== design/utr_datapath.sv
// UART transmit and receive datapath with its register port
//
// Local design decisions: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "utr_cfg.svh"

// Contract
// - Zero parity: send parity bit 0, never flag parity error on receive.
// - No parity: no parity bit sent or expected, no parity error.
// - With power enabled the serial output idles high before transmit enable.
// - Power plus transmit enable lets a buffer write start a frame.
// - Buffer moves to shift register; start, parity, stop bits added automatically.
// - Transmit done interrupt right after the last stop bit, one or two stops.
// - With nothing pending the transmitter stays idle until the next write.
// - Next byte accepted once shifting starts; frames follow without gaps.
// - Status bit 1 buffer full: 0 writable, 1 write not allowed; the code still takes a write when full, overwriting the pending byte.
// - Status bit 0 shift busy: 1 during transmission, 0 when done.
// - Continuous transmission steps flags 10, 11, 01; judge by full flag.
// - Receiver samples input only with power and receive enable set.
// - Falling edge starts counter; after divisor count, low confirms start bit.
// - Data shifted in at baud rate; stop bit copies buffer, raises done.
// - Overrun sets its flag and leaves the receive buffer unchanged.
// - Parity error keeps receiving to stop bit; interrupt at frame end.
// - Receiver checks one stop bit only; a second one is ignored.
// - Power off: output held high, input treated as constant high.
// - Frame: start, 7 or 8 data bits, optional parity, 1 or 2 stops.
// - Even parity: odd count of ones in data plus parity is an error.
module utr_datapath (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic [`UTR_ADDR_W-1:0] addr_in,
  input wire logic [7:0] wr_data_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  output logic [7:0] rd_data_out,
  input wire logic serial_in_pin_in,
  output logic serial_out_pin_out,
  output logic transmit_done_irq_out,
  output logic receive_done_irq_out,
  output logic receive_error_irq_out
);
  // --------------------------------------------------------------------------
  // Registers and decodes
  // --------------------------------------------------------------------------
  logic [7:0] uart_mode_reg;
  logic [7:0] baud_divisor_reg;
  logic [2:0] rx_err_reg;
  logic [7:0] receive_buffer_reg;
  logic rxbuf_full_reg;
  logic [7:0] transmit_buffer_reg;
  logic tx_buffer_full_reg;
  logic tx_shift_busy_reg;
  utr_pkg::utr_tx_state_t tx_state_reg;
  logic [11:0] tx_shift_reg;
  logic [3:0] tx_left_reg;
  logic [8:0] tx_cnt_reg;
  utr_pkg::utr_rx_state_t rx_state_reg;
  logic [8:0] rx_cnt_reg;
  logic [3:0] rx_idx_reg;
  logic [9:0] rx_shift_reg;
  logic rx_prev_reg;
  logic rx_sync;
  logic power;
  logic tx_on;
  logic rx_on;
  logic [1:0] par_mode;
  logic has_par;
  logic char8;
  logic [8:0] bit_period;
  logic rx_level;
  logic tx_wr;
  logic err_rd;
  logic rxbuf_rd;

  assign power = uart_mode_reg[`UTR_MODE_POWER];
  assign tx_on = power & uart_mode_reg[`UTR_MODE_TXE];
  assign rx_on = power & uart_mode_reg[`UTR_MODE_RXE];
  assign par_mode = uart_mode_reg[`UTR_MODE_PS_HI:`UTR_MODE_PS_LO];
  assign has_par = (par_mode != `UTR_PAR_NONE);
  assign char8 = uart_mode_reg[`UTR_MODE_CL];
  // One bit lasts twice the divisor, so the divisor count lands mid-bit
  assign bit_period = {baud_divisor_reg, 1'b0};
  assign rx_level = power ? rx_sync : 1'b1;
  assign tx_wr = wr_en_in & (addr_in == `UTR_OFF_TXBUF) & tx_on;
  assign err_rd = rd_en_in & (addr_in == `UTR_OFF_RXERR);
  assign rxbuf_rd = rd_en_in & (addr_in == `UTR_OFF_RXBUF);

  // Input pin synchroniser
  utr_sync3 u_rx_sync (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .async_in(serial_in_pin_in),
    .sync_out(rx_sync)
  );

  // --------------------------------------------------------------------------
  // Register port
  // --------------------------------------------------------------------------
  // Software-writable configuration
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      uart_mode_reg <= `UTR_MODE_RST;
      baud_divisor_reg <= `UTR_BAUD_RST;
    end
    else if (wr_en_in)
    begin
      if (addr_in == `UTR_OFF_MODE)
      begin
        uart_mode_reg <= wr_data_in;
      end
      else if (addr_in == `UTR_OFF_BAUD)
      begin
        baud_divisor_reg <= wr_data_in;
      end
    end
  end

  // Read data one cycle after the strobe; unmapped offsets read zero
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      rd_data_out <= 8'h00;
    end
    else if (rd_en_in)
    begin
      if (addr_in == `UTR_OFF_MODE)
      begin
        rd_data_out <= uart_mode_reg;
      end
      else if (addr_in == `UTR_OFF_RXERR)
      begin
        rd_data_out <= {5'h00, rx_err_reg};
      end
      else if (addr_in == `UTR_OFF_TXSTAT)
      begin
        rd_data_out <= {6'h00, tx_buffer_full_reg, tx_shift_busy_reg};
      end
      else if (addr_in == `UTR_OFF_TXBUF)
      begin
        rd_data_out <= transmit_buffer_reg;
      end
      else if (addr_in == `UTR_OFF_RXBUF)
      begin
        rd_data_out <= receive_buffer_reg;
      end
      else if (addr_in == `UTR_OFF_BAUD)
      begin
        rd_data_out <= baud_divisor_reg;
      end
      else
      begin
        rd_data_out <= 8'h00;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Transmitter
  // --------------------------------------------------------------------------
  logic [11:0] tx_frame_next;
  logic [3:0] tx_len;
  logic tx_par_bit;
  logic tx_last_tick;
  logic tx_load;

  // Frame image, LSB goes out first; unused top bits stay high as stops
  always_comb
  begin
    if (par_mode == `UTR_PAR_EVEN)
    begin
      tx_par_bit = char8 ? ^transmit_buffer_reg : ^transmit_buffer_reg[6:0];
    end
    else if (par_mode == `UTR_PAR_ODD)
    begin
      tx_par_bit = char8 ? ~^transmit_buffer_reg : ~^transmit_buffer_reg[6:0];
    end
    else
    begin
      tx_par_bit = 1'b0;
    end
    tx_frame_next = char8 ? {3'h7, transmit_buffer_reg, 1'b0} : {4'hF, transmit_buffer_reg[6:0], 1'b0};
    if (has_par)
    begin
      if (char8)
      begin
        tx_frame_next[9] = tx_par_bit;
      end
      else
      begin
        tx_frame_next[8] = tx_par_bit;
      end
    end
    tx_len = 4'h1 + (char8 ? 4'h8 : 4'h7) + {3'h0, has_par} + (uart_mode_reg[`UTR_MODE_SL] ? 4'h2 : 4'h1);
  end

  assign tx_last_tick = (tx_state_reg == utr_pkg::TX_SHIFT) && (tx_cnt_reg <= 9'h001) && (tx_left_reg == 4'h1);
  assign tx_load = tx_buffer_full_reg && ((tx_state_reg == utr_pkg::TX_IDLE) || tx_last_tick);

  // Transmit buffer holds the written byte
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      transmit_buffer_reg <= 8'h00;
    end
    else if (tx_wr)
    begin
      transmit_buffer_reg <= wr_data_in;
    end
  end

  // Buffer-full flag; a write in the load cycle keeps it set
  always_ff @(posedge clk_in)
  begin
    if (srst_in || !tx_on)
    begin
      tx_buffer_full_reg <= 1'b0;
    end
    else if (tx_wr)
    begin
      tx_buffer_full_reg <= 1'b1;
    end
    else if (tx_load)
    begin
      tx_buffer_full_reg <= 1'b0;
    end
  end

  // Shift engine; clearing enable or power resets it and idles the pin high
  always_ff @(posedge clk_in)
  begin
    if (srst_in || !tx_on)
    begin
      tx_state_reg <= utr_pkg::TX_IDLE;
      tx_shift_reg <= 12'hFFF;
      tx_left_reg <= 4'h0;
      tx_cnt_reg <= 9'h000;
      tx_shift_busy_reg <= 1'b0;
      serial_out_pin_out <= 1'b1;
      transmit_done_irq_out <= 1'b0;
    end
    else
    begin
      transmit_done_irq_out <= tx_last_tick;
      if (tx_load)
      begin
        tx_state_reg <= utr_pkg::TX_SHIFT;
        tx_shift_reg <= tx_frame_next;
        serial_out_pin_out <= tx_frame_next[0];
        tx_left_reg <= tx_len;
        tx_cnt_reg <= bit_period;
        tx_shift_busy_reg <= 1'b1;
      end
      else if (tx_last_tick)
      begin
        tx_state_reg <= utr_pkg::TX_IDLE;
        tx_shift_busy_reg <= 1'b0;
        serial_out_pin_out <= 1'b1;
        tx_left_reg <= 4'h0;
      end
      else if (tx_state_reg == utr_pkg::TX_SHIFT)
      begin
        if (tx_cnt_reg <= 9'h001)
        begin
          tx_shift_reg <= {1'b1, tx_shift_reg[11:1]};
          serial_out_pin_out <= tx_shift_reg[1];
          tx_left_reg <= tx_left_reg - 4'h1;
          tx_cnt_reg <= bit_period;
        end
        else
        begin
          tx_cnt_reg <= tx_cnt_reg - 9'h001;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Receiver
  // --------------------------------------------------------------------------
  logic [3:0] rx_stop_idx;
  logic rx_fin;
  logic [7:0] rx_data;
  logic rx_par;
  logic rx_pe;
  logic rx_fe;
  logic rx_ove;

  // Only one stop position is sampled, whatever the stop length
  assign rx_stop_idx = (char8 ? 4'h8 : 4'h7) + {3'h0, has_par};
  assign rx_fin = (rx_state_reg == utr_pkg::RX_DATA) && (rx_cnt_reg <= 9'h001) && (rx_idx_reg == rx_stop_idx);
  assign rx_data = char8 ? rx_shift_reg[7:0] : {1'b0, rx_shift_reg[6:0]};
  assign rx_par = char8 ? rx_shift_reg[8] : rx_shift_reg[7];
  // Zero and no parity never flag; even and odd check the full count
  assign rx_pe = ((par_mode == `UTR_PAR_EVEN) && (^{rx_data, rx_par})) ||
                 ((par_mode == `UTR_PAR_ODD) && !(^{rx_data, rx_par}));
  assign rx_fe = !rx_level;
  assign rx_ove = rxbuf_full_reg;

  // Edge history of the filtered input
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      rx_prev_reg <= 1'b1;
    end
    else
    begin
      rx_prev_reg <= rx_level;
    end
  end

  // Start detection and bit sampling
  always_ff @(posedge clk_in)
  begin
    if (srst_in || !rx_on)
    begin
      rx_state_reg <= utr_pkg::RX_IDLE;
      rx_cnt_reg <= 9'h000;
      rx_idx_reg <= 4'h0;
      rx_shift_reg <= 10'h000;
      receive_done_irq_out <= 1'b0;
      receive_error_irq_out <= 1'b0;
    end
    else
    begin
      // Errors wait until the stop position, then one interrupt per frame
      receive_done_irq_out <= rx_fin && (uart_mode_reg[`UTR_MODE_ISRM] || !(rx_pe || rx_fe || rx_ove));
      receive_error_irq_out <= rx_fin && !uart_mode_reg[`UTR_MODE_ISRM] && (rx_pe || rx_fe || rx_ove);
      case (rx_state_reg)
        utr_pkg::RX_IDLE:
        begin
          if (rx_prev_reg && !rx_level)
          begin
            rx_state_reg <= utr_pkg::RX_START;
            rx_cnt_reg <= {1'b0, baud_divisor_reg};
          end
        end
        utr_pkg::RX_START:
        begin
          if (rx_cnt_reg <= 9'h001)
          begin
            rx_state_reg <= rx_level ? utr_pkg::RX_IDLE : utr_pkg::RX_DATA;
            rx_cnt_reg <= bit_period;
            rx_idx_reg <= 4'h0;
          end
          else
          begin
            rx_cnt_reg <= rx_cnt_reg - 9'h001;
          end
        end
        utr_pkg::RX_DATA:
        begin
          if (rx_cnt_reg <= 9'h001)
          begin
            rx_shift_reg[rx_idx_reg] <= rx_level;
            rx_cnt_reg <= bit_period;
            rx_idx_reg <= rx_idx_reg + 4'h1;
            if (rx_fin)
            begin
              rx_state_reg <= utr_pkg::RX_IDLE;
            end
          end
          else
          begin
            rx_cnt_reg <= rx_cnt_reg - 9'h001;
          end
        end
        default:
        begin
          rx_state_reg <= utr_pkg::RX_IDLE;
        end
      endcase
    end
  end

  // Receive buffer; an overrun keeps the old byte
  always_ff @(posedge clk_in)
  begin
    if (srst_in || !power)
    begin
      receive_buffer_reg <= `UTR_RXBUF_RST;
      rxbuf_full_reg <= 1'b0;
    end
    else if (rx_fin && !rx_ove)
    begin
      receive_buffer_reg <= rx_data;
      rxbuf_full_reg <= 1'b1;
    end
    else if (rxbuf_rd)
    begin
      rxbuf_full_reg <= 1'b0;
    end
  end

  // Error status clears on read; a new error in that cycle survives
  always_ff @(posedge clk_in)
  begin
    if (srst_in || !power)
    begin
      rx_err_reg <= 3'h0;
    end
    else
    begin
      rx_err_reg <= (err_rd ? 3'h0 : rx_err_reg) | (rx_fin ? {rx_fe, rx_pe, rx_ove} : 3'h0);
    end
  end

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);

  sequence seq_tx_last;
    tx_on && tx_last_tick;
  endsequence
  sequence seq_rx_finish;
    rx_on && rx_fin;
  endsequence

  chk_idle_high: assert property (!tx_on |=> serial_out_pin_out)
    else $error("serial output not high while transmitter off");
  chk_done_timing: assert property (seq_tx_last |=> transmit_done_irq_out ##1 !transmit_done_irq_out)
    else $error("transmit done not a single pulse after last stop");
  chk_gapless_next: assert property (seq_tx_last ##0 tx_buffer_full_reg |=> tx_shift_busy_reg && !serial_out_pin_out)
    else $error("pending byte did not start at once");
  chk_idle_stays: assert property (seq_tx_last ##0 !tx_buffer_full_reg |=> !tx_shift_busy_reg && serial_out_pin_out)
    else $error("transmitter did not go idle");
  chk_full_on_write: assert property (tx_wr |=> tx_buffer_full_reg)
    else $error("buffer full flag not set by write");
  chk_busy_on_load: assert property (tx_on && tx_load |=> tx_shift_busy_reg && !tx_buffer_full_reg [*1])
    else $error("busy flag or full flag wrong after load");
  chk_start_reject: assert property (rx_on && rx_state_reg == utr_pkg::RX_START && rx_cnt_reg <= 9'h001 && rx_level
                                     |=> rx_state_reg == utr_pkg::RX_IDLE)
    else $error("high level accepted as start bit");
  chk_overrun_keep: assert property (seq_rx_finish ##0 rxbuf_full_reg |=>
                                     receive_buffer_reg == $past(receive_buffer_reg) && rx_err_reg[`UTR_ERR_OVE])
    else $error("overrun changed the receive buffer");
  chk_rx_copy: assert property (seq_rx_finish ##0 !rxbuf_full_reg |=>
                                receive_buffer_reg == $past(rx_data) && (receive_done_irq_out || receive_error_irq_out))
    else $error("frame not copied with interrupt");
  chk_no_parity_err: assert property (seq_rx_finish ##0 (par_mode == `UTR_PAR_ZERO || !has_par) ##0
                                      !rx_err_reg[`UTR_ERR_PE] |=> !rx_err_reg[`UTR_ERR_PE])
    else $error("parity error flagged without parity check");
  chk_rx_off: assert property (!rx_on |=> rx_state_reg == utr_pkg::RX_IDLE && !receive_done_irq_out)
    else $error("receiver active while disabled");
endmodule
`default_nettype wire

// ===== design/utr_cfg.svh
// Register offsets, field positions, reset values and codes of the UART datapath
`ifndef UTR_CFG_SVH
`define UTR_CFG_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define UTR_ADDR_W 3
`define UTR_OFF_MODE 3'h0
`define UTR_OFF_RXERR 3'h1
`define UTR_OFF_TXSTAT 3'h2
`define UTR_OFF_TXBUF 3'h3
`define UTR_OFF_RXBUF 3'h4
`define UTR_OFF_BAUD 3'h5

// ----------------------------------------------------------------------------
// Mode register fields
// ----------------------------------------------------------------------------
`define UTR_MODE_POWER 7
`define UTR_MODE_TXE 6
`define UTR_MODE_RXE 5
`define UTR_MODE_PS_HI 4
`define UTR_MODE_PS_LO 3
`define UTR_MODE_CL 2
`define UTR_MODE_SL 1
`define UTR_MODE_ISRM 0

// ----------------------------------------------------------------------------
// Parity codes
// ----------------------------------------------------------------------------
`define UTR_PAR_NONE 2'h0
`define UTR_PAR_ZERO 2'h1
`define UTR_PAR_ODD 2'h2
`define UTR_PAR_EVEN 2'h3

// ----------------------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------------------
`define UTR_ERR_OVE 0
`define UTR_ERR_PE 1
`define UTR_ERR_FE 2
`define UTR_TXST_TBF 1
`define UTR_TXST_TSF 0

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define UTR_MODE_RST 8'h01
`define UTR_RXBUF_RST 8'hFF
`define UTR_BAUD_RST 8'h10
`define UTR_SYNC_RST 1'h1

`endif

// ===== design/utr_pkg.sv
// Types shared by the UART datapath files
package utr_pkg;
  typedef enum logic [0:0] {TX_IDLE, TX_SHIFT} utr_tx_state_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA} utr_rx_state_t;
endpackage

// ===== design/utr_sync3.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none
`include "utr_cfg.svh"

module utr_sync3 (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic async_in,
  output logic sync_out
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  // Chain plus filter; the first stage feeds only the second
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      s1_reg <= `UTR_SYNC_RST;
      s2_reg <= `UTR_SYNC_RST;
      s3_reg <= `UTR_SYNC_RST;
      sync_out <= `UTR_SYNC_RST;
    end
    else
    begin
      s1_reg <= async_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg)
      begin
        sync_out <= s3_reg;
      end
    end
  end
endmodule
`default_nettype wire

// ===== sim/utr_peer.sv
// Remote serial device model on the far side of the UART line
`timescale 1ns/10ps
`default_nettype none
module utr_peer (
  input wire logic clk_in,
  input wire logic line_in,
  output logic line_out,
  output logic got_vld_out,
  output logic [8:0] got_out
);
  int bit_cyc = 4;
  int nbits = 8;
  bit par_en = 1'b0;

  // ------------
  // Sender
  // ------------
  // Start, data LSB first, optional parity, one stop; idles high after
  task automatic send(input logic [7:0] d, input logic p);
    line_out <= 1'b0;
    repeat (bit_cyc) @(posedge clk_in);
    for (int i = 0; i < nbits + int'(par_en); i++)
    begin
      line_out <= (i < nbits) ? d[i] : p;
      repeat (bit_cyc) @(posedge clk_in);
    end
    line_out <= 1'b1;
    repeat (bit_cyc) @(posedge clk_in);
  endtask

  // ------------
  // Decoder
  // ------------
  // Mid-bit sampling; a low stop bit drops the frame so the bench sees it
  initial
  begin
    line_out = 1'b1;
    got_vld_out = 1'b0;
    got_out = '0;
    forever
    begin
      @(negedge line_in);
      repeat (bit_cyc / 2) @(posedge clk_in);
      if (line_in === 1'b0)
      begin
        got_out = '0;
        for (int i = 0; i < nbits + int'(par_en); i++)
        begin
          repeat (bit_cyc) @(posedge clk_in);
          got_out[(i < nbits) ? i : 8] = line_in;
        end
        repeat (bit_cyc) @(posedge clk_in);
        got_vld_out <= line_in;
        @(posedge clk_in);
        got_vld_out <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ===== sim/utr_datapath_bench.sv
// Self-checking bench for the UART datapath against a remote serial model
`timescale 1ns/10ps
`default_nettype none
`include "utr_cfg.svh"
module utr_datapath_bench;
  logic clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic [`UTR_ADDR_W-1:0] addr_in = '0;
  logic [7:0] wr_data_in = '0;
  logic wr_en_in = 1'b0;
  logic rd_en_in = 1'b0;
  logic [7:0] rd_data_out;
  logic rx_line, tx_line, tx_done, rx_done, rx_err, got_vld;
  logic rd_d1 = 1'b0;
  logic [8:0] got;
  logic [31:0] seed = 32'hBA2B774C;
  logic [7:0] rdq[$];
  logic [8:0] txq[$];
  int error_cnt = 0;
  int tests_run = 0;
  int tx_n = 0, rx_n = 0, er_n = 0, cyc = 0;
  int et = 0, ed = 0, ee = 0;

  always #2 clk_in = ~clk_in;

  utr_datapath DUT (.clk_in(clk_in), .srst_in(srst_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
    .wr_en_in(wr_en_in), .rd_en_in(rd_en_in), .rd_data_out(rd_data_out), .serial_in_pin_in(rx_line),
    .serial_out_pin_out(tx_line), .transmit_done_irq_out(tx_done), .receive_done_irq_out(rx_done),
    .receive_error_irq_out(rx_err));
  utr_peer peer (.clk_in(clk_in), .line_in(tx_line), .line_out(rx_line), .got_vld_out(got_vld), .got_out(got));

  // ------------
  // Helpers
  // ------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      $display("BAD %s expected %h seen %h", n, e, g);
      error_cnt++;
    end
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Register bus: one-cycle strobes, read result noted for the watcher
  task automatic wr(input logic [`UTR_ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge clk_in);
    wr_en_in <= 1'b1;
    addr_in <= a;
    wr_data_in <= d;
    @(posedge clk_in);
    wr_en_in <= 1'b0;
  endtask

  task automatic rd(input logic [`UTR_ADDR_W-1:0] a, input logic [7:0] e);
    rdq.push_back(e);
    @(posedge clk_in);
    rd_en_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_en_in <= 1'b0;
  endtask

  // Bounded wait for an interrupt count (0 transmit, 1 receive, 2 error)
  task automatic waitc(input int w, input int n);
    int k;
    int c;
    k = 0;
    c = (w == 0) ? tx_n : (w == 1) ? rx_n : er_n;
    while (c < n && k < 3000)
    begin
      @(posedge clk_in);
      k++;
      c = (w == 0) ? tx_n : (w == 1) ? rx_n : er_n;
    end
    chk("irq_count", n, c);
  endtask

  // Watcher: read data is checked in the cycle after the strobe
  always @(posedge clk_in)
  begin
    rd_d1 <= rd_en_in;
    if (rd_d1)
      chk("rd_data", rdq.pop_front(), rd_data_out);
    if (got_vld)
      chk("tx_frame", txq.pop_front(), got);
    tx_n <= tx_n + int'(tx_done);
    rx_n <= rx_n + int'(rx_done);
    er_n <= er_n + int'(rx_err);
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      error_cnt++;
      results();
    end
  end

  // ------------
  // Scenarios
  // ------------
  initial
  begin
    logic [7:0] d;
    logic p;
    repeat (4) @(posedge clk_in);
    srst_in <= 1'b0;
    rd(`UTR_OFF_MODE, `UTR_MODE_RST);
    rd(`UTR_OFF_BAUD, `UTR_BAUD_RST);
    rd(`UTR_OFF_RXBUF, `UTR_RXBUF_RST);
    rd(3'h7, 8'h00);
    chk("off_out", 1'b1, tx_line);
    // Power without transmit enable: line high, buffer write ignored
    wr(`UTR_OFF_BAUD, 8'h02);
    wr(`UTR_OFF_MODE, 8'h84);
    wr(`UTR_OFF_TXBUF, 8'hA5);
    repeat (60) @(posedge clk_in);
    chk("idle_out", 1'b1, tx_line);
    chk("no_frame", 0, tx_n);
    rd(`UTR_OFF_TXSTAT, 8'h00);
    // Every parity, length and stop setting; zero parity echoed with a 1
    for (int m = 0; m < 16; m++)
    begin
      wr(`UTR_OFF_MODE, 8'hE0 | 8'(m << 1));
      peer.nbits = 7 + m[1];
      peer.par_en = (m[3:2] != `UTR_PAR_NONE);
      d = 8'(rnd());
      if (!m[1])
        d[7] = 1'b0;
      p = (m[3:2] == `UTR_PAR_EVEN) ? ^d : (m[3:2] == `UTR_PAR_ODD) ? ~^d : 1'b0;
      txq.push_back({p, d});
      wr(`UTR_OFF_TXBUF, d);
      et++;
      waitc(0, et);
      rd(`UTR_OFF_TXSTAT, 8'h00);
      peer.send(d, p ^ (m[3:2] == `UTR_PAR_ZERO));
      ed++;
      waitc(1, ed);
      rd(`UTR_OFF_RXERR, 8'h00);
      rd(`UTR_OFF_RXBUF, d);
    end
    // Even parity with a wrong bit: error pulse only, buffer still written
    wr(`UTR_OFF_MODE, 8'hFC);
    peer.nbits = 8;
    peer.send(8'h01, 1'b0);
    ee++;
    waitc(2, ee);
    chk("done_count", ed, rx_n);
    rd(`UTR_OFF_RXERR, 8'h02);
    rd(`UTR_OFF_RXBUF, 8'h01);
    rd(`UTR_OFF_RXERR, 8'h00);
    // Same error with errors merged into the done pulse
    wr(`UTR_OFF_MODE, 8'hFD);
    peer.send(8'h01, 1'b0);
    ed++;
    waitc(1, ed);
    chk("err_count", ee, er_n);
    rd(`UTR_OFF_RXERR, 8'h02);
    rd(`UTR_OFF_RXBUF, 8'h01);
    // Two frames unread, two stops set but one sent: overrun keeps the first byte
    wr(`UTR_OFF_MODE, 8'hE6);
    peer.par_en = 1'b0;
    peer.send(8'h3C, 1'b0);
    peer.send(8'hC3, 1'b0);
    ed++;
    ee++;
    waitc(1, ed);
    waitc(2, ee);
    rd(`UTR_OFF_RXERR, 8'h01);
    rd(`UTR_OFF_RXBUF, 8'h3C);
    // Continuous transmission: flags 01, 11, 01, 00 and no gap
    d = 8'(rnd());
    txq.push_back({1'b0, d});
    wr(`UTR_OFF_TXBUF, d);
    repeat (4) @(posedge clk_in);
    rd(`UTR_OFF_TXSTAT, 8'h01);
    d = 8'(rnd());
    txq.push_back({1'b0, d});
    wr(`UTR_OFF_TXBUF, d);
    rd(`UTR_OFF_TXSTAT, 8'h03);
    et++;
    waitc(0, et);
    chk("no_gap", 1'b0, tx_line);
    rd(`UTR_OFF_TXSTAT, 8'h01);
    et++;
    waitc(0, et);
    rd(`UTR_OFF_TXSTAT, 8'h00);
    // Receiver off, then power off: nothing received, buffer reset
    wr(`UTR_OFF_MODE, 8'hC4);
    peer.send(8'h5A, 1'b0);
    repeat (20) @(posedge clk_in);
    chk("rx_off", ed, rx_n);
    rd(`UTR_OFF_RXBUF, 8'h3C);
    wr(`UTR_OFF_MODE, 8'h00);
    peer.send(8'h00, 1'b0);
    repeat (20) @(posedge clk_in);
    chk("pwr_off", ed, rx_n);
    chk("pwr_out", 1'b1, tx_line);
    rd(`UTR_OFF_RXBUF, `UTR_RXBUF_RST);
    repeat (4) @(posedge clk_in);
    // A frame dropped by the far side leaves its note behind
    chk("tx_left", 0, txq.size());
    results();
  end
endmodule
`default_nettype wire
